// ==== include/svd_regs.svh ====
`ifndef SVD_REGS_SVH
`define SVD_REGS_SVH

`define SVD_ADDR_W          12
`define SVD_DATA_W          32
`define SVD_CTRL_W          8
`define SVD_OFF_CTRL        12'h000
`define SVD_OFF_FLAG        12'h004
`define SVD_OFF_IEN         12'h008
`define SVD_OFF_GIE         12'h00c
`define SVD_CTRL_RST        8'h05
`define SVD_LVL_EXT         4'hf
`define SVD_BIT_EVT         0
`define SVD_BIT_GIE         0
`define SVD_BIT_IEN         0
`define SVD_CMP_GE          0
`define SVD_CMP_LE          1
`define SVD_CLK_PERIOD_NS   50
`define SVD_REF_STARTUP_NS  20000
`define SVD_CNT_W           16

`endif

// ==== include/svd_pkg.sv ====
`include "svd_regs.svh"

package svd_pkg;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       dir;
		logic       unused;
		logic       stable;
		logic       en;
		logic [3:0] level;
	} svd_ctrl_s;

	// Reference warm-up sequence
	typedef enum logic [1:0] {
		SVD_OFF,
		SVD_WARM,
		SVD_READY
	} svd_ref_e;

	// Controls toward the analog divider and comparator
	typedef struct packed {
		logic       power_en;
		logic       dir;
		logic       ext_sel;
		logic [3:0] tap_sel;
	} svd_ana_s;

endpackage

// ==== design/svd_ctrl.sv ====
// Notes on behaviour
// RL1: Detector power follows the enable bit; off when it is zero.
// RL2: Direction set trips at supply at or above; clear at or below.
// RL3: Stable bit is read-only, shows whether detector circuitry has settled.
// RL4: Event flag cannot set until the stable bit reads one.
// RL5: Each enable rising holds stable low for the warm-up interval.
// RL6: Four-bit level field picks one of 15 points; 1110 highest, 0000 lowest.
// RL7: Level all ones routes the external trip input to the comparator.
// RL8: Comparator trip condition sets the voltage event flag.
// RL9: Unused control bit reads zero and ignores writes.
// RL10: Software disables, writes level, sets direction, then enables.
// RL11: Software clears a stale event flag after enabling.
// RL12: Interrupt needs event enable and global enable; flag sets regardless.
// RL13: Warm-up interval is fixed time, not tied to clock frequency.
// RL14: Detector keeps running in sleep, sets flag and wakes the core.
// RL15: Any reset returns control register to reset state, detector off.
// RL16: Control resets to 0x05: level 0101, other bits clear.
// RL17: Comparator output is synchronised before it may set the flag.
//
// Design decisions made here: register access over APB and the register addresses.

`include "svd_regs.svh"

module svd_ctrl #(
	parameter int STARTUP_NS = `SVD_REF_STARTUP_NS,
	parameter int CNT_W      = `SVD_CNT_W
) (
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`SVD_ADDR_W-1:0]   paddr,
	input  wire logic [`SVD_DATA_W-1:0]   pwdata,
	output logic      [`SVD_DATA_W-1:0]   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [1:0]               cmp_async,
	input  wire logic                     sleep_mode,
	output svd_pkg::svd_ana_s             ana,
	output logic                          irq,
	output logic                          wake_req
);
	import svd_pkg::*;

	// Warm-up length, rounded up to whole cycles
	localparam int STARTUP_CYC =
		(STARTUP_NS + `SVD_CLK_PERIOD_NS - 1) / `SVD_CLK_PERIOD_NS;

	// ****************************************
	// Declarations
	// ****************************************
	svd_ctrl_s              ctrl_r;
	svd_ctrl_s              ctrl_nxt;
	svd_ctrl_s              wr_ctrl;
	svd_ref_e               ref_r;
	svd_ref_e               ref_nxt;
	logic [CNT_W-1:0]       cnt_r;
	logic [CNT_W-1:0]       cnt_nxt;
	logic [1:0]             cmp_s1_r;
	logic [1:0]             cmp_s2_r;
	logic                   flag_r;
	logic                   flag_nxt;
	logic                   ien_r;
	logic                   gie_r;
	logic [`SVD_DATA_W-1:0] prdata_r;
	logic [`SVD_DATA_W-1:0] prdata_nxt;
	logic                   pready_r;
	logic                   pslverr_r;
	svd_ana_s               ana_r;
	logic                   irq_r;
	logic                   wake_r;

	// ****************************************
	// Bus decode
	// ****************************************
	wire setup_ph = psel & ~penable;
	wire access   = psel & penable & pready_r;
	wire wr_acc   = access & pwrite;
	wire rd_acc   = access & ~pwrite;
	wire hit_ctrl = (paddr == `SVD_OFF_CTRL);
	wire hit_flag = (paddr == `SVD_OFF_FLAG);
	wire hit_ien  = (paddr == `SVD_OFF_IEN);
	wire hit_gie  = (paddr == `SVD_OFF_GIE);
	wire hit_any  = hit_ctrl | hit_flag | hit_ien | hit_gie;
	wire wr_ctrl_hit = wr_acc & hit_ctrl;
	wire wr_ien_hit  = wr_acc & hit_ien;
	wire wr_gie_hit  = wr_acc & hit_gie;

	wire ref_stable = ctrl_r.en & (ref_r == SVD_READY);

	// Stable bit composed live, stored copy never used
	wire [`SVD_CTRL_W-1:0] ctrl_view = {ctrl_r.dir, 1'b0, ref_stable,      // see RL3, RL9
		ctrl_r.en, ctrl_r.level};

	wire [`SVD_DATA_W-1:0] rd_mux =
		hit_ctrl ? {{(`SVD_DATA_W-`SVD_CTRL_W){1'b0}}, ctrl_view} :
		hit_flag ? {{(`SVD_DATA_W-1){1'b0}}, flag_r} :
		hit_ien  ? {{(`SVD_DATA_W-1){1'b0}}, ien_r} :
		hit_gie  ? {{(`SVD_DATA_W-1){1'b0}}, gie_r} :
		{`SVD_DATA_W{1'b0}};

	// Read data captured in setup, presented in access
	assign prdata_nxt = (setup_ph & ~pwrite) ? rd_mux : {`SVD_DATA_W{1'b0}};

	// ****************************************
	// Control register
	// ****************************************
	assign wr_ctrl = svd_ctrl_s'(pwdata[`SVD_CTRL_W-1:0]);

	// Only direction, enable and level are writable
	assign ctrl_nxt = wr_ctrl_hit ?
		svd_ctrl_s'{dir: wr_ctrl.dir, unused: 1'b0, stable: 1'b0,          // see RL3, RL9
		  en: wr_ctrl.en, level: wr_ctrl.level} : ctrl_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl_r <= svd_ctrl_s'(`SVD_CTRL_RST);                          // see RL15, RL16
			ien_r  <= 1'b0;
			gie_r  <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			if (wr_ien_hit)
			begin
				ien_r <= pwdata[`SVD_BIT_IEN];
			end
			if (wr_gie_hit)
			begin
				gie_r <= pwdata[`SVD_BIT_GIE];
			end
		end
	end

	// ****************************************
	// Reference warm-up timer
	// ****************************************
	// Fixed time converted from clock period; off whenever disabled
	always_comb
	begin
		ref_nxt = ref_r;
		cnt_nxt = cnt_r;
		unique case (ref_r)
			SVD_OFF:
			begin
				if (ctrl_r.en)
				begin
					ref_nxt = SVD_WARM;                                    // see RL5, RL13
					cnt_nxt = CNT_W'(STARTUP_CYC - 1);
				end
			end
			SVD_WARM:
			begin
				if (cnt_r == {CNT_W{1'b0}})
				begin
					ref_nxt = SVD_READY;
				end
				else
				begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			SVD_READY:
			begin
				ref_nxt = SVD_READY;
			end
		endcase
		if (!ctrl_r.en)
		begin
			ref_nxt = SVD_OFF;                                             // see RL5
			cnt_nxt = {CNT_W{1'b0}};
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ref_r <= SVD_OFF;
			cnt_r <= {CNT_W{1'b0}};
		end
		else
		begin
			ref_r <= ref_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ****************************************
	// Comparator synchroniser
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cmp_s1_r <= 2'h0;
			cmp_s2_r <= 2'h0;
		end
		else
		begin
			cmp_s1_r <= cmp_async;                                         // see RL17
			cmp_s2_r <= cmp_s1_r;
		end
	end

	// ****************************************
	// Event flag
	// ****************************************
	wire trip = ctrl_r.dir ? cmp_s2_r[`SVD_CMP_GE] : cmp_s2_r[`SVD_CMP_LE];  // see RL2
	wire evt_set = ctrl_r.en & ref_stable & trip;                          // see RL4, RL8
	// Clear only a bit that the read actually returned
	wire flag_clr = rd_acc & hit_flag & prdata_r[`SVD_BIT_EVT];

	// Set wins over the read clear
	assign flag_nxt = evt_set | (flag_r & ~flag_clr);                     // see RL8, RL12

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			flag_r <= 1'b0;
		end
		else
		begin
			flag_r <= flag_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			prdata_r  <= {`SVD_DATA_W{1'b0}};
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			ana_r     <= '0;
			irq_r     <= 1'b0;
			wake_r    <= 1'b0;
		end
		else
		begin
			prdata_r  <= prdata_nxt;
			pready_r  <= setup_ph;
			pslverr_r <= setup_ph & ~hit_any;
			ana_r.power_en <= ctrl_r.en;                                   // see RL1
			ana_r.dir      <= ctrl_r.dir;
			ana_r.ext_sel  <= (ctrl_r.level == `SVD_LVL_EXT);              // see RL7
			ana_r.tap_sel  <= ctrl_r.level;                                // see RL6
			irq_r  <= flag_r & ien_r & gie_r;                              // see RL12
			wake_r <= flag_r & ien_r & sleep_mode;                         // see RL14
		end
	end

	assign prdata   = prdata_r;
	assign pready   = pready_r;
	assign pslverr  = pslverr_r;
	assign ana      = ana_r;
	assign irq      = irq_r;
	assign wake_req = wake_r;

	// ****************************************
	// Checks
	// ****************************************
	logic [CNT_W-1:0] en_age_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst || !ctrl_r.en)
		begin
			en_age_r <= {CNT_W{1'b0}};
		end
		else if (en_age_r <= CNT_W'(STARTUP_CYC))
		begin
			en_age_r <= en_age_r + CNT_W'(1);
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_stable_timing: assert property (                                     // see RL5
		ref_stable == (ctrl_r.en && (en_age_r > CNT_W'(STARTUP_CYC))))
		else $error("stable flag timing wrong");

	a_stable_off: assert property (                                        // see RL3
		(wr_ctrl_hit && !wr_ctrl.en) |=> !ref_stable ##1 !ref_stable)
		else $error("stable flag survived disable");

	a_flag_gated: assert property (                                        // see RL4
		$rose(flag_r) |-> $past(ref_stable) && $past(ctrl_r.en))
		else $error("event flag set before stable");

	a_flag_high: assert property (                                         // see RL2
		(ctrl_r.en && ref_stable && ctrl_r.dir && cmp_s2_r[`SVD_CMP_GE]) |=> flag_r)
		else $error("rising trip missed");

	a_flag_low: assert property (                                          // see RL8
		(ctrl_r.en && ref_stable && !ctrl_r.dir && cmp_s2_r[`SVD_CMP_LE]) |=> flag_r)
		else $error("falling trip missed");

	a_sync_path: assert property (                                         // see RL17
		$rose(flag_r) |-> $past(trip))
		else $error("flag set without synchronised trip");

	a_power_follow: assert property (                                      // see RL1
		ana_r.power_en == $past(ctrl_r.en))
		else $error("power enable does not follow control");

	a_ext_select: assert property (                                        // see RL7
		ana_r.ext_sel == ($past(ctrl_r.level) == `SVD_LVL_EXT))
		else $error("external input select wrong");

	a_unused_zero: assert property (                                       // see RL9
		(pready_r && !pwrite && hit_ctrl) |-> !prdata_r[6])
		else $error("unused control bit not zero");

	a_irq_gate: assert property (                                          // see RL12
		irq_r == $past(flag_r && ien_r && gie_r))
		else $error("interrupt gating wrong");

	a_wake_sleep: assert property (                                        // see RL14
		wake_r == $past(flag_r && ien_r && sleep_mode))
		else $error("wake request wrong");

	a_reset_ctrl: assert property (                                        // see RL16
		$past(rst) |-> (ctrl_r == svd_ctrl_s'(`SVD_CTRL_RST)) && !ref_stable)
		else $error("control not at reset value");

	a_read_clear: assert property (                                        // see RL8
		(rd_acc && hit_flag && prdata_r[`SVD_BIT_EVT] && !evt_set) |=> !flag_r)
		else $error("event flag not cleared by read");

	a_set_wins: assert property (                                          // see RL8
		(rd_acc && hit_flag && evt_set) |=> flag_r)
		else $error("event lost against read clear");

	a_ctrl_write: assert property (                                        // see RL6
		wr_ctrl_hit |=> (ctrl_r.level == $past(wr_ctrl.level)) && (ctrl_r.en == $past(wr_ctrl.en)))
		else $error("control write not taken");

endmodule // svd_ctrl

// ==== dv/testbench.sv ====
`include "svd_regs.svh"

module testbench import svd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clk_sys, rst, psel, penable, pwrite;
	logic              pready, pslverr, sleep_mode, irq, wake_req, err;
	logic       [11:0] paddr;
	logic       [31:0] pwdata, prdata, rd;
	logic       [1:0]  cmp_async;
	logic       [7:0]  v;
	svd_ana_s          ana;
	int                num_errors, num_checks, seed;

	svd_ctrl #(.STARTUP_NS(500), .CNT_W(16)) svd_ctrl_i (.clk_sys(clk_sys), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_async(cmp_async),
		.sleep_mode(sleep_mode), .ana(ana), .irq(irq), .wake_req(wake_req));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] exp_ana(input logic [7:0] c);
		return {25'h0, c[4], c[7], c[3:0] == 4'hf, c[3:0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	initial
	begin
		cyc(5000);
		num_errors++;
		conclude();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		{rst, psel, penable, pwrite, sleep_mode} = 5'b10000;
		{paddr, pwdata, cmp_async} = '0;
		seed = 80848;
		cyc(16);
		rst <= 1'b0;
		cyc(2);
		chk("ana", 32'h05, {25'h0, ana});
		rdc("ctrl", `SVD_OFF_CTRL, 32'h05);
		$display("test reset done");
		// Random control with detector off; corner values first
		for (int i = 0; i < 24; i++)
		begin
			v = 8'($random(seed));
			v[4] = 1'b0;
			if (i == 0)
				v = 8'hef;
			if (i == 1)
				v = 8'h60;
			apb(1'b1, `SVD_OFF_CTRL, {24'h0, v});
			cyc(2);
			chk("ana", exp_ana(v), {25'h0, ana});
			rdc("ctrl", `SVD_OFF_CTRL, {24'h0, v & 8'h9f});
			chk("err", 32'h0, {31'h0, err});
		end
		$display("test control done");
		cmp_async <= 2'b11;
		apb(1'b1, `SVD_OFF_CTRL, 32'h93);
		rdc("ctrl", `SVD_OFF_CTRL, 32'h93);
		rdc("flag", `SVD_OFF_FLAG, 32'h0);
		chk("ana", exp_ana(8'h93), {25'h0, ana});
		cyc(14);
		rdc("ctrl", `SVD_OFF_CTRL, 32'hb3);
		cyc(4);
		rdc("flag", `SVD_OFF_FLAG, 32'h1);
		$display("test warmup done");
		// Disable, level, direction, enable order kept for every case
		for (int k = 0; k < 8; k++)
		begin
			v = {k[2], 7'h13};
			apb(1'b1, `SVD_OFF_CTRL, 32'h03);
			apb(1'b1, `SVD_OFF_CTRL, {24'h0, v & 8'hef});
			apb(1'b1, `SVD_OFF_CTRL, {24'h0, v});
			cmp_async <= k[1:0];
			cyc(20);
			apb(1'b0, `SVD_OFF_FLAG, 32'h0);
			cyc(8);
			rdc("flag", `SVD_OFF_FLAG, {31'h0, k[2] ? k[0] : k[1]});
		end
		$display("test direction done");
		apb(1'b1, `SVD_OFF_IEN, 32'h1);
		cyc(4);
		chk("irq", 32'h0, {31'h0, irq});
		sleep_mode <= 1'b1;
		cyc(3);
		chk("wake", 32'h1, {31'h0, wake_req});
		apb(1'b1, `SVD_OFF_GIE, 32'h1);
		cyc(3);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, `SVD_OFF_IEN, 32'h0);
		cyc(3);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b1, `SVD_OFF_IEN, 32'h1);
		cmp_async <= 2'b00;
		sleep_mode <= 1'b0;
		cyc(6);
		rdc("flag", `SVD_OFF_FLAG, 32'h1);
		cyc(3);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test interrupt done");
		rdc("unmapped", 12'h010, 32'h0);
		chk("err", 32'h1, {31'h0, err});
		apb(1'b1, `SVD_OFF_CTRL, 32'h83);
		rdc("ctrl", `SVD_OFF_CTRL, 32'h83);
		chk("ana", exp_ana(8'h83), {25'h0, ana});
		apb(1'b1, `SVD_OFF_CTRL, 32'h9a);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		rdc("ctrl", `SVD_OFF_CTRL, 32'h05);
		rdc("ien", `SVD_OFF_IEN, 32'h0);
		$display("test misc done");
		conclude();
	end
endmodule // testbench
